// [olp_addr_resolve.sv]
// Data address resolver for file-register operands
`timescale 1ns/1ps
module olp_addr_resolve import olp_pkg::*; (
    input wire logic clock, // Core clock
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic [7:0] fileAddr, // 8-bit file operand
    input wire logic accessSel, // 0 access bank, 1 banked
    input wire logic [3:0] bankSel, // Bank select register
    input wire logic extEn, // Extended set enable
    input wire logic [11:0] ptrBase, // Index pointer value
    output logic [11:0] dataAddr // Resolved data address
);
    // Candidate addresses and selection
    wire indexed = !accessSel && extEn && (fileAddr <= OLP_IDX_LIMIT);
    wire lowAccess = fileAddr < OLP_ACC_SPLIT;
    wire [11:0] accessAddr = lowAccess ? {OLP_ACC_LO_BANK, fileAddr}
                                       : {OLP_ACC_HI_BANK, fileAddr};
    wire [11:0] bankAddr = {bankSel, fileAddr};
    wire [11:0] indexAddr = ptrBase + {4'h0, fileAddr};
    assign dataAddr = indexed ? indexAddr : (accessSel ? bankAddr : accessAddr);

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    accessBank_a: assert property (!accessSel && !extEn |->
        dataAddr[11:8] == (lowAccess ? OLP_ACC_LO_BANK : OLP_ACC_HI_BANK))
        else $error("access bank address wrong");
    bankSelect_a: assert property (accessSel |->
        dataAddr == {bankSel, fileAddr})
        else $error("banked address wrong");
    indexedOffset_a: assert property (!accessSel && extEn && fileAddr <= 8'h5f |->
        dataAddr == 12'(ptrBase + {4'h0, fileAddr}))
        else $error("indexed offset address wrong");
endmodule : olp_addr_resolve

// [olp_core.sv]
// Core executing OR-with-file, move-file and pointer-load over AXI4-Lite
`timescale 1ns/1ps
module olp_core import olp_pkg::*; (
    input wire logic clock, // Core clock, 100 MHz
    input wire logic sys_rst, // Asynchronous reset, active high
    input wire logic [OLP_AXI_AW-1:0] s_axi_awaddr, // Write address
    input wire logic s_axi_awvalid, // Write address valid
    output logic s_axi_awready, // Write address ready
    input wire logic [31:0] s_axi_wdata, // Write data
    input wire logic [3:0] s_axi_wstrb, // Write byte strobes
    input wire logic s_axi_wvalid, // Write data valid
    output logic s_axi_wready, // Write data ready
    output logic [1:0] s_axi_bresp, // Write response
    output logic s_axi_bvalid, // Write response valid
    input wire logic s_axi_bready, // Write response ready
    input wire logic [OLP_AXI_AW-1:0] s_axi_araddr, // Read address
    input wire logic s_axi_arvalid, // Read address valid
    output logic s_axi_arready, // Read address ready
    output logic [31:0] s_axi_rdata, // Read data
    output logic [1:0] s_axi_rresp, // Read response
    output logic s_axi_rvalid, // Read data valid
    input wire logic s_axi_rready, // Read data ready
    output olp_mem_req_t memReq, // Data memory request
    input wire logic [7:0] memRdData // Data memory read byte
);
    // Bus slave state
    logic awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
    logic [1:0] bResp_q, rResp_q;
    logic [OLP_AXI_AW-1:0] awAddr_q;
    logic [31:0] wData_q, rData_q;
    logic [3:0] wStrb_q;
    // Execution state
    olp_state_t state_q, state_d;
    olp_op_t op_q, newOp;
    logic [1:0] phase_q;
    logic [15:0] instr_q;
    logic [1:0] ptrSel_q;
    logic [7:0] fileData_q, result_q, accum_q;
    logic neg_q, zero_q, extEn_q, illegal_q;
    logic [3:0] bankSel_q;
    logic [3:0] ptrHi_q [OLP_PTR_COUNT];
    logic [7:0] ptrLo_q [OLP_PTR_COUNT];
    olp_mem_req_t memReq_q;
    logic [11:0] dataAddr;
    logic [31:0] rdWord;
    logic rdHit;

    // Bus outputs straight from flops
    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rdata = rData_q;
    assign s_axi_rresp = rResp_q;
    assign memReq = memReq_q;

    // Write decode: one write is done once address and data are both held
    wire awTake = s_axi_awvalid && awReady_q;
    wire wTake = s_axi_wvalid && wReady_q;
    wire doWrite = !awReady_q && !wReady_q && !bValid_q;
    wire selInstr = awAddr_q[7:2] == OLP_OFS_INSTR[7:2];
    wire selStatus = awAddr_q[7:2] == OLP_OFS_STATUS[7:2];
    wire selAccum = awAddr_q[7:2] == OLP_OFS_ACCUM[7:2];
    wire selBank = awAddr_q[7:2] == OLP_OFS_BANK[7:2];
    wire selConfig = awAddr_q[7:2] == OLP_OFS_CONFIG[7:2];
    wire selPtr = (awAddr_q[7:2] == OLP_OFS_PTR0[7:2]) || (awAddr_q[7:2] == OLP_OFS_PTR1[7:2])
                  || (awAddr_q[7:2] == OLP_OFS_PTR2[7:2]);
    wire busy = state_q == OLP_ST_RUN;
    wire wrMapped = selInstr || selStatus || selAccum || selBank || selConfig || selPtr;
    wire wrBusyHit = busy && (selInstr || selAccum || selBank || selConfig);
    wire wrBadStrb = selInstr && (wStrb_q[1:0] != 2'h3);
    wire wrOk = doWrite && wrMapped && !wrBusyHit && !wrBadStrb;
    wire instrGo = wrOk && selInstr;
    wire illegalClr = wrOk && selStatus && wStrb_q[0] && wData_q[OLP_SB_ILLEGAL];

    // Instruction word decode
    wire [15:0] word = wData_q[15:0];
    wire isOr = word[15:10] == OLP_OPC_OR;
    wire isMov = word[15:10] == OLP_OPC_MOV;
    wire isLfHi = (word[15:6] == OLP_OPC_LF1) && (word[5:4] != OLP_PTR_SEL_BAD);
    wire isLfLo = word[15:8] == OLP_OPC_LF2;
    wire waitLo = state_q == OLP_ST_WAIT2;
    wire legal = waitLo ? isLfLo : (isOr || isMov || isLfHi);
    wire startRun = instrGo && legal;
    wire badWord = instrGo && !legal;
    assign newOp = waitLo ? OLP_OP_LFL : (isOr ? OLP_OP_OR : (isMov ? OLP_OP_MOV : OLP_OP_LFH));

    // Operand fields of the running instruction
    wire fileOp = (op_q == OLP_OP_OR) || (op_q == OLP_OP_MOV);
    wire destFile = instr_q[OLP_IB_DEST];
    wire inQ1 = busy && phase_q == OLP_Q1;
    wire inQ2 = busy && phase_q == OLP_Q2;
    wire inQ3 = busy && phase_q == OLP_Q3;
    wire inQ4 = busy && phase_q == OLP_Q4;
    wire [7:0] resultD = (op_q == OLP_OP_OR) ? (accum_q | fileData_q) : fileData_q;

    // Address resolution for the file operand
    olp_addr_resolve uResolve (
        .clock(clock),
        .sys_rst(sys_rst),
        .fileAddr(instr_q[7:0]),
        .accessSel(instr_q[OLP_IB_ACCESS]),
        .bankSel(bankSel_q),
        .extEn(extEn_q),
        .ptrBase({ptrHi_q[OLP_PTR_INDEX], ptrLo_q[OLP_PTR_INDEX]}),
        .dataAddr(dataAddr)
    );

    // Write channels
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            awReady_q <= 1'b1;
            wReady_q <= 1'b1;
            bValid_q <= 1'b0;
            bResp_q <= OLP_RESP_OKAY;
            awAddr_q <= '0;
            wData_q <= '0;
            wStrb_q <= '0;
        end else begin
            if (awTake) begin
                awReady_q <= 1'b0;
                awAddr_q <= s_axi_awaddr;
            end else if (bValid_q && s_axi_bready) begin
                awReady_q <= 1'b1;
            end
            if (wTake) begin
                wReady_q <= 1'b0;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (bValid_q && s_axi_bready) begin
                wReady_q <= 1'b1;
            end
            if (doWrite) begin
                bValid_q <= 1'b1;
                bResp_q <= wrOk ? OLP_RESP_OKAY : OLP_RESP_SLVERR;
            end else if (s_axi_bready) begin
                bValid_q <= 1'b0;
            end
        end
    end

    // Read data selection
    always_comb begin
        rdHit = 1'b1;
        rdWord = '0;
        case (s_axi_araddr[7:2])
            OLP_OFS_INSTR[7:2]: rdWord = {16'h0000, instr_q};
            OLP_OFS_STATUS[7:2]: rdWord = {27'h0, illegal_q, zero_q, neg_q, waitLo, busy};
            OLP_OFS_ACCUM[7:2]: rdWord = {24'h0, accum_q};
            OLP_OFS_BANK[7:2]: rdWord = {28'h0, bankSel_q};
            OLP_OFS_CONFIG[7:2]: rdWord = {31'h0, extEn_q};
            OLP_OFS_PTR0[7:2]: rdWord = {20'h0, ptrHi_q[0], ptrLo_q[0]};
            OLP_OFS_PTR1[7:2]: rdWord = {20'h0, ptrHi_q[1], ptrLo_q[1]};
            OLP_OFS_PTR2[7:2]: rdWord = {20'h0, ptrHi_q[2], ptrLo_q[2]};
            default: rdHit = 1'b0;
        endcase
    end

    // Read channels: data one cycle after the address is taken
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            arReady_q <= 1'b1;
            rValid_q <= 1'b0;
            rData_q <= '0;
            rResp_q <= OLP_RESP_OKAY;
        end else if (s_axi_arvalid && arReady_q) begin
            arReady_q <= 1'b0;
            rValid_q <= 1'b1;
            rData_q <= rdWord;
            rResp_q <= rdHit ? OLP_RESP_OKAY : OLP_RESP_SLVERR;
        end else if (rValid_q && s_axi_rready) begin
            arReady_q <= 1'b1;
            rValid_q <= 1'b0;
        end
    end

    // Sequencer next state
    always_comb begin
        state_d = state_q;
        case (state_q)
            OLP_ST_IDLE: if (startRun) state_d = OLP_ST_RUN;
            OLP_ST_RUN: begin
                if (phase_q == OLP_Q4) begin
                    state_d = (op_q == OLP_OP_LFH) ? OLP_ST_WAIT2 : OLP_ST_IDLE;
                end
            end
            OLP_ST_WAIT2: begin
                if (startRun) begin
                    state_d = OLP_ST_RUN;
                end else if (badWord) begin
                    state_d = OLP_ST_IDLE;
                end
            end
            default: state_d = OLP_ST_IDLE;
        endcase
    end

    // Sequencer, phase counter and instruction latch
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= OLP_ST_IDLE;
            phase_q <= OLP_Q1;
            op_q <= OLP_OP_OR;
            instr_q <= '0;
            ptrSel_q <= '0;
            illegal_q <= 1'b0;
        end else begin
            state_q <= state_d;
            phase_q <= busy ? 2'(phase_q + 2'h1) : OLP_Q1;
            if (startRun) begin
                op_q <= newOp;
                instr_q <= word;
            end
            if (startRun && !waitLo) ptrSel_q <= word[5:4];
            illegal_q <= badWord || (illegal_q && !illegalClr);
        end
    end

    // Q1 issue read, Q2 capture, Q3 process and post write, Q4 retire
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            memReq_q <= '0;
            fileData_q <= '0;
            result_q <= '0;
        end else begin
            if (inQ1) begin
                memReq_q.addr <= dataAddr;
            end
            memReq_q.re <= inQ1 && fileOp;
            if (inQ2 && fileOp) fileData_q <= memRdData;
            if (inQ3) begin
                result_q <= resultD;
                memReq_q.wdata <= resultD;
            end
            memReq_q.we <= inQ3 && fileOp && destFile;
        end
    end

    // Accumulator, flags, bank select and extended enable
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            accum_q <= OLP_ACCUM_RST;
            neg_q <= 1'b0;
            zero_q <= 1'b0;
            bankSel_q <= OLP_BANK_RST;
            extEn_q <= OLP_EXT_RST;
        end else begin
            if (inQ4 && fileOp) begin
                if (!destFile) accum_q <= result_q;
                neg_q <= result_q[7];
                zero_q <= result_q == 8'h00;
            end else if (wrOk && selAccum && wStrb_q[0]) begin
                accum_q <= wData_q[7:0];
            end
            if (wrOk && selBank && wStrb_q[0]) bankSel_q <= wData_q[3:0];
            if (wrOk && selConfig && wStrb_q[0]) extEn_q <= wData_q[OLP_CB_EXTEN];
        end
    end

    // Pointer registers, written only by the pointer-load cycles
    for (genvar g = 0; g < OLP_PTR_COUNT; g++) begin : gPtr
        wire hit = inQ4 && (ptrSel_q == 2'(g));
        always_ff @(posedge clock or posedge sys_rst) begin
            if (sys_rst) begin
                ptrHi_q[g] <= OLP_PTRHI_RST;
                ptrLo_q[g] <= OLP_PTRLO_RST;
            end else begin
                if (hit && op_q == OLP_OP_LFH) ptrHi_q[g] <= instr_q[3:0];
                if (hit && op_q == OLP_OP_LFL) ptrLo_q[g] <= instr_q[7:0];
            end
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    sequence quarters_s;
        (busy && phase_q == 2'h0) ##1 (busy && phase_q == 2'h1)
        ##1 (busy && phase_q == 2'h2) ##1 (busy && phase_q == 2'h3);
    endsequence

    orCompute_a: assert property (inQ4 && op_q == OLP_OP_OR |->
        result_q == (accum_q | fileData_q))
        else $error("OR result wrong");
    accumDest_a: assert property (inQ4 && fileOp && !destFile |=>
        accum_q == $past(result_q) && !memReq_q.we)
        else $error("accumulator destination not written");
    fileDest_a: assert property (memReq_q.we |->
        inQ4 && fileOp && destFile && memReq_q.wdata == result_q)
        else $error("file write at wrong moment or value");
    moveFlags_a: assert property (inQ4 && op_q == OLP_OP_MOV |=>
        zero_q == ($past(fileData_q) == 8'h00) && neg_q == $past(fileData_q[7]))
        else $error("move flags wrong");
    ptrFlags_a: assert property (inQ4 && !fileOp |=>
        $stable(neg_q) && $stable(zero_q) && $stable(accum_q))
        else $error("pointer load touched flags");
    secondWord_a: assert property (waitLo && instrGo && word[15:8] != 8'hf0 |=>
        illegal_q && state_q == OLP_ST_IDLE)
        else $error("bad second word accepted");
    ptrHigh_a: assert property (inQ4 && op_q == OLP_OP_LFH |=>
        ptrHi_q[ptrSel_q] == $past(instr_q[3:0]) && state_q == OLP_ST_WAIT2)
        else $error("pointer high byte not loaded");
    quarterSeq_a: assert property (startRun |=> quarters_s ##1 !busy)
        else $error("instruction cycle not four phases");
endmodule : olp_core

// [olp_core_tb.sv]
// Self-checking testbench of the OR / move / pointer-load core
`timescale 1ns/1ps
module olp_core_tb import olp_pkg::*;;
    logic clock = 1'b0, sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, memRdData;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    olp_mem_req_t memReq;
    logic [7:0] mem [4096];
    logic [33:0] expQ [$];
    int err_count = 0, n_tests = 0;
    logic [7:0] acc, f, v;
    logic [3:0] b;
    logic [11:0] k, kp2, ad;
    logic zf = 1'b0, nf = 1'b0;

    olp_core DUT (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .memReq, .memRdData);

    // Clock of 10 ns
    initial begin
        forever #5 clock = ~clock;
    end

    // Data memory: read only while the read strobe stands, write at the edge ending the write
    assign memRdData = memReq.re ? mem[memReq.addr] : 8'hxx;
    always @(posedge clock) begin
        if (memReq.we) mem[memReq.addr] <= memReq.wdata;
    end

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    // Scoreboard: oldest note against each response handshake
    always @(posedge clock) begin
        if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, expQ.pop_front());
        if (s_axi_bvalid && s_axi_bready) chk({s_axi_bresp, 32'h0}, expQ.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
        input logic [1:0] r);
        bit ad, wd;
        expQ.push_back({r, 32'h0});
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        ad = 0;
        wd = 0;
        while (!(ad && wd)) begin
            @(posedge clock);
            if (s_axi_awready && !ad) begin
                ad = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !wd) begin
                wd = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
        expQ.push_back({r, d});
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clock); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clock); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask : rd

    // Instruction write, then the four phases run out
    task automatic ex(input logic [15:0] i);
        wr(OLP_OFS_INSTR, {16'h0, i}, 4'hf, OLP_RESP_OKAY);
        repeat (5) @(posedge clock);
    endtask : ex

    function automatic logic [31:0] st(input logic ill, input logic w);
        return {27'h0, ill, zf, nf, w, 1'b0};
    endfunction : st

    task automatic accflags(input logic [7:0] r);
        zf = (r == 8'h00);
        nf = r[7];
    endtask : accflags

    task automatic finish_test;
        $display("Checks %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : finish_test

    // Watchdog
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        finish_test();
    end

    initial begin
        void'($urandom(4));
        foreach (mem[i]) mem[i] = 8'($urandom);
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        // Reset values and unmapped accesses
        for (int i = 0; i < 8; i++) rd(8'(4 * i), 32'h0, OLP_RESP_OKAY);
        rd(8'h24, 32'h0, OLP_RESP_SLVERR);
        wr(8'h28, 32'h1, 4'hf, OLP_RESP_SLVERR);
        $display("reset test done");
        // OR into accumulator from the low access bank
        acc = 8'($urandom);
        f = 8'($urandom_range(95, 0));
        v = acc | mem[{4'h0, f}];
        wr(OLP_OFS_ACCUM, {24'h0, acc}, 4'hf, OLP_RESP_OKAY);
        ex({OLP_OPC_OR, 1'b0, 1'b0, f});
        accflags(v);
        acc = v;
        rd(OLP_OFS_ACCUM, {24'h0, acc}, OLP_RESP_OKAY);
        rd(OLP_OFS_STATUS, st(1'b0, 1'b0), OLP_RESP_OKAY);
        // OR written back to a banked file register
        b = 4'($urandom);
        f = 8'($urandom);
        ad = {b, f};
        v = acc | mem[ad];
        wr(OLP_OFS_BANK, {28'h0, b}, 4'hf, OLP_RESP_OKAY);
        ex({OLP_OPC_OR, 1'b1, 1'b1, f});
        accflags(v);
        chk({26'h0, mem[ad]}, {26'h0, v});
        rd(OLP_OFS_ACCUM, {24'h0, acc}, OLP_RESP_OKAY);
        $display("or test done");
        // Move from the high access bank, zero then negative
        for (int j = 0; j < 2; j++) begin
            f = 8'h80 | 8'($urandom);
            mem[{4'hf, f}] = (j == 1) ? 8'h80 : 8'h00;
            ex({OLP_OPC_MOV, 1'b0, 1'b0, f});
            acc = mem[{4'hf, f}];
            accflags(acc);
            rd(OLP_OFS_ACCUM, {24'h0, acc}, OLP_RESP_OKAY);
            rd(OLP_OFS_STATUS, st(1'b0, 1'b0), OLP_RESP_OKAY);
        end
        // Move at the top of a bank back onto itself
        ad = {b, 8'hff};
        v = mem[ad];
        ex({OLP_OPC_MOV, 1'b1, 1'b1, 8'hff});
        accflags(v);
        chk({26'h0, mem[ad]}, {26'h0, v});
        rd(OLP_OFS_STATUS, st(1'b0, 1'b0), OLP_RESP_OKAY);
        $display("move test done");
        // Pointer loads, two words each, flags untouched
        for (int s = 0; s < 3; s++) begin
            k = 12'($urandom);
            ex({OLP_OPC_LF1, 2'(s), k[11:8]});
            rd(OLP_OFS_STATUS, st(1'b0, 1'b1), OLP_RESP_OKAY);
            rd(8'(OLP_OFS_PTR0 + 4 * s), {20'h0, k[11:8], 8'h00}, OLP_RESP_OKAY);
            ex({OLP_OPC_LF2, k[7:0]});
            rd(8'(OLP_OFS_PTR0 + 4 * s), {20'h0, k}, OLP_RESP_OKAY);
            rd(OLP_OFS_STATUS, st(1'b0, 1'b0), OLP_RESP_OKAY);
            kp2 = k;
        end
        rd(OLP_OFS_ACCUM, {24'h0, acc}, OLP_RESP_OKAY);
        $display("pointer test done");
        // Indexed literal offset, and its upper limit
        wr(OLP_OFS_CONFIG, 32'h1, 4'hf, OLP_RESP_OKAY);
        f = 8'($urandom_range(95, 0));
        ad = kp2 + {4'h0, f};
        ex({OLP_OPC_MOV, 1'b0, 1'b0, f});
        acc = mem[ad];
        rd(OLP_OFS_ACCUM, {24'h0, acc}, OLP_RESP_OKAY);
        ex({OLP_OPC_MOV, 1'b0, 1'b0, 8'h60});
        acc = mem[12'hf60];
        accflags(acc);
        rd(OLP_OFS_ACCUM, {24'h0, acc}, OLP_RESP_OKAY);
        $display("indexed test done");
        // Bad pointer select, sticky flag cleared by writing one
        ex({OLP_OPC_LF1, OLP_PTR_SEL_BAD, 4'h5});
        rd(OLP_OFS_STATUS, st(1'b1, 1'b0), OLP_RESP_OKAY);
        wr(OLP_OFS_STATUS, 32'h10, 4'hf, OLP_RESP_OKAY);
        rd(OLP_OFS_STATUS, st(1'b0, 1'b0), OLP_RESP_OKAY);
        // Pointer load cut short by a word that is not its second half
        ex({OLP_OPC_LF1, 2'h1, 4'ha});
        ex({OLP_OPC_MOV, 1'b0, 1'b0, 8'h60});
        rd(OLP_OFS_STATUS, st(1'b1, 1'b0), OLP_RESP_OKAY);
        rd(OLP_OFS_ACCUM, {24'h0, acc}, OLP_RESP_OKAY);
        wr(OLP_OFS_INSTR, 32'h1000, 4'h1, OLP_RESP_SLVERR);
        $display("illegal test done");
        finish_test();
    end
endmodule : olp_core_tb

// [olp_pkg.sv]
// Constants, register map and types of the OR / move / pointer-load core
// Operation
// - The OR-with-file opcode (000100 d a f) ORs the accumulator with the file register and updates N and Z.
// - Destination bit 0 sends the result to the accumulator, 1 writes it back to the file register.
// - Access bit 0 resolves the file address in the fixed access bank, not through the bank select register.
// - Access bit 1 takes the bank from the bank select register.
// - Access bit 0 with the extended set enabled and an address of at most 95 uses indexed literal offset.
// - The move-file opcode (010100 d a f) copies the file register to the destination and updates N and Z.
// - The move-file source may be any location of the selected 256-byte bank.
// - Pointer load has two words: 1110111000 with select and bits 11..8, then 11110000 with bits 7..0.
// - Pointer load takes two cycles: high byte written in the first, low byte in the second.
package olp_pkg;
    // Bus geometry and register byte offsets
    localparam int OLP_AXI_AW = 8;
    localparam logic [7:0] OLP_OFS_INSTR = 8'h00;
    localparam logic [7:0] OLP_OFS_STATUS = 8'h04;
    localparam logic [7:0] OLP_OFS_ACCUM = 8'h08;
    localparam logic [7:0] OLP_OFS_BANK = 8'h0c;
    localparam logic [7:0] OLP_OFS_CONFIG = 8'h10;
    localparam logic [7:0] OLP_OFS_PTR0 = 8'h14;
    localparam logic [7:0] OLP_OFS_PTR1 = 8'h18;
    localparam logic [7:0] OLP_OFS_PTR2 = 8'h1c;
    localparam logic [1:0] OLP_RESP_OKAY = 2'h0;
    localparam logic [1:0] OLP_RESP_SLVERR = 2'h2;
    // Status and config field positions
    localparam int OLP_SB_BUSY = 0;
    localparam int OLP_SB_WAIT2 = 1;
    localparam int OLP_SB_NEG = 2;
    localparam int OLP_SB_ZERO = 3;
    localparam int OLP_SB_ILLEGAL = 4;
    localparam int OLP_CB_EXTEN = 0;
    // Instruction fields and opcodes
    localparam int OLP_IB_DEST = 9;
    localparam int OLP_IB_ACCESS = 8;
    localparam logic [5:0] OLP_OPC_OR = 6'h04;
    localparam logic [5:0] OLP_OPC_MOV = 6'h14;
    localparam logic [9:0] OLP_OPC_LF1 = 10'h3b8;
    localparam logic [7:0] OLP_OPC_LF2 = 8'hf0;
    localparam logic [1:0] OLP_PTR_SEL_BAD = 2'h3;
    localparam int OLP_PTR_COUNT = 3;
    localparam int OLP_PTR_INDEX = 2;
    // Data space layout
    localparam logic [7:0] OLP_IDX_LIMIT = 8'h5f;
    localparam logic [7:0] OLP_ACC_SPLIT = 8'h60;
    localparam logic [3:0] OLP_ACC_LO_BANK = 4'h0;
    localparam logic [3:0] OLP_ACC_HI_BANK = 4'hf;
    // Phase timing: four quarter phases per instruction cycle
    localparam logic [1:0] OLP_Q1 = 2'h0;
    localparam logic [1:0] OLP_Q2 = 2'h1;
    localparam logic [1:0] OLP_Q3 = 2'h2;
    localparam logic [1:0] OLP_Q4 = 2'h3;
    // Reset values
    localparam logic [7:0] OLP_ACCUM_RST = 8'h00;
    localparam logic [3:0] OLP_BANK_RST = 4'h0;
    localparam logic [3:0] OLP_PTRHI_RST = 4'h0;
    localparam logic [7:0] OLP_PTRLO_RST = 8'h00;
    localparam logic OLP_EXT_RST = 1'b0;

    typedef enum logic [2:0] {
        OLP_ST_IDLE = 3'b001,
        OLP_ST_RUN = 3'b010,
        OLP_ST_WAIT2 = 3'b100
    } olp_state_t;

    typedef enum logic [1:0] {
        OLP_OP_OR = 2'h0,
        OLP_OP_MOV = 2'h1,
        OLP_OP_LFH = 2'h2,
        OLP_OP_LFL = 2'h3
    } olp_op_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0] wdata;
        logic re;
        logic we;
    } olp_mem_req_t;
endpackage : olp_pkg
